// ---- verilog/dch_map.svh ----
// Register offsets, field positions, reset values and timing counts
// Summary of operation
// - Head field three bits, four in four-bit mode
// - ID byte: bad block, size, zero, head
// - Busy: reads return status, writes are ignored
// - Status bit 6 is ready; not ready aborts
// - Status bit 5 is fault; fault aborts
// - Status bit 4 always reads one
// - Status bits 7, 3, 1, 2 read zero when idle
// - Status bit 0 flags non-recoverable error
// - Ready and fault latched at completion until read
// - Status read clears disk controller interrupt
// - Command write sets busy and starts command
// - Command write clears disk controller interrupt
// - Legacy port bits 2,1 written by microcontroller
// - Legacy port bits 7 and 6 read one
// - Legacy bits 5,4 mirror interrupt and DMA request
// - Legacy busy set by reset and selection
// - Legacy bit 0 shows host transfer enable
// - Host pointer: 8-bit low, 7-bit high, reload base
// - Armed: load pointer at zero count, then disarm
// - Transfer count loads with the pointer
`ifndef DCH_MAP_SVH
`define DCH_MAP_SVH
`define DCH_OFF_SDH       8'h26
`define DCH_OFF_STATUS    8'h27
`define DCH_OFF_LEGACY    8'h2d
`define DCH_OFF_DRVCFG    8'h2e
`define DCH_OFF_PTR_LO    8'h30
`define DCH_OFF_PTR_HI    8'h31
`define DCH_ST_ERR        0
`define DCH_ST_CIP        1
`define DCH_ST_BUFFER_DATA_REQUEST       3
`define DCH_ST_SEEK       4
`define DCH_ST_WF         5
`define DCH_ST_RDY        6
`define DCH_ST_BUSY       7
`define DCH_SEEK_TIED     1'b1
`define DCH_RST_BYTE      8'h00
`define DCH_RST_PTR       15'h0000
`define DCH_RST_XFER      12'h000
`define DCH_CLK_NS        20
`define DCH_CMD_NS        2000
`define DCH_CMD_CYC ((`DCH_CMD_NS + `DCH_CLK_NS - 1) / `DCH_CLK_NS)
`endif

// ---- verilog/dch_pkg.sv ----
// Shared types of the disk controller register block
package dch_pkg;
    typedef logic [7:0] dch_byte_t;
    typedef enum logic [0:0] {
        CMD_IDLE,
        CMD_RUN
    } dch_cmd_e;
endpackage

// ---- verilog/dch_cmd_exec.sv ----
// Command execution timer with drive condition abort
`timescale 1ns/100ps
`include "dch_map.svh"
module dch_cmd_exec (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_start,
    input  wire logic i_drive_ready,
    input  wire logic i_write_fault,
    output logic      o_busy,
    output logic      o_done,
    output logic      o_error
);
    localparam logic [7:0] CMD_LAST = 8'(`DCH_CMD_CYC - 1);

    dch_pkg::dch_cmd_e state_ff;
    logic [7:0]        cnt_ff;
    logic              abort;

    // Any drive problem during a command ends it at once
    assign abort = !i_drive_ready || i_write_fault;

    // Sequencer and run timer
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= dch_pkg::CMD_IDLE;
            cnt_ff   <= 8'h00;
            o_done   <= 1'b0;
            o_error  <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state_ff)
                dch_pkg::CMD_IDLE: begin
                    if (i_start) begin
                        state_ff <= dch_pkg::CMD_RUN;
                        cnt_ff   <= 8'h00;
                        o_error  <= 1'b0;
                    end
                end
                dch_pkg::CMD_RUN: begin
                    if (abort) begin
                        state_ff <= dch_pkg::CMD_IDLE;
                        o_done   <= 1'b1;
                        o_error  <= 1'b1;
                    end else if (cnt_ff == CMD_LAST) begin
                        state_ff <= dch_pkg::CMD_IDLE;
                        o_done   <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff + 8'h01;
                    end
                end
            endcase
        end
    end

    assign o_busy = (state_ff == dch_pkg::CMD_RUN);
endmodule

// ---- verilog/dch_regs.sv ----
// Drive controller status, command, legacy host and host pointer registers
`timescale 1ns/100ps
`include "dch_map.svh"
module dch_regs (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_uc_addr,
    input  wire logic [7:0]  i_uc_wdata,
    input  wire logic        i_uc_wr,
    input  wire logic        i_uc_rd,
    input  wire logic        i_drive_ready_in,
    input  wire logic        i_write_fault_in,
    input  wire logic        i_four_bit_head,
    input  wire logic        i_bad_block,
    input  wire logic        i_buffer_data_request,
    input  wire logic        i_host_interrupt_out,
    input  wire logic        i_host_dma_request_out,
    input  wire logic        i_host_xfer_en,
    input  wire logic        i_legacy_select,
    input  wire logic        i_legacy_busy_clr,
    input  wire logic        i_arm_host_pointer,
    input  wire logic        i_host_byte_done,
    input  wire logic [11:0] i_host_xfer_count,
    output logic [7:0]       o_uc_rdata,
    output logic [7:0]       o_command,
    output logic             o_busy,
    output logic             o_command_in_progress,
    output logic             o_disk_ctrl_interrupt,
    output logic [7:0]       o_id_format_byte,
    output logic [7:0]       o_legacy_status,
    output logic [7:0]       o_drive_config,
    output logic             o_arm_host_pointer,
    output logic [14:0]      o_host_buf_cnt,
    output logic [11:0]      o_xfer_cnt
);

    // Head field width follows the head mode; upper bit masked in 3-bit
    function automatic logic [3:0] head_field(input logic [7:0] drive_head_select,
                                              input logic four);
        head_field = four ? drive_head_select[3:0] : {1'b0, drive_head_select[2:0]};
    endfunction

    logic        rdy_meta_ff;
    logic        rdy_sync_ff;
    logic        wf_meta_ff;
    logic        wf_sync_ff;
    logic [7:0]  sdh_ff;
    logic [7:0]  cmd_ff;
    logic        irq_ff;
    logic        lat_ff;
    logic        lat_rdy_ff;
    logic        lat_wf_ff;
    logic [1:0]  leg_wr_ff;
    logic        leg_busy_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  ptr_lo_ff;
    logic [6:0]  ptr_hi_ff;
    logic        arm_ff;
    logic [11:0] xfer_ff;
    logic [14:0] hbc_ff;
    logic        exec_busy;
    logic        exec_done;
    logic        exec_err;
    logic        cmd_start;
    logic        wr_ok;
    logic        st_rd;
    logic        arm_load;
    logic        rdy_view;
    logic        wf_view;
    logic [7:0]  status_img;
    logic [7:0]  nxt_rdata;
    logic [7:0]  nxt_legacy;

    // Drive pins arrive asynchronously and pass two flops first
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdy_meta_ff <= 1'b0;
            rdy_sync_ff <= 1'b0;
            wf_meta_ff  <= 1'b0;
            wf_sync_ff  <= 1'b0;
        end else begin
            rdy_meta_ff <= i_drive_ready_in;
            rdy_sync_ff <= rdy_meta_ff;
            wf_meta_ff  <= i_write_fault_in;
            wf_sync_ff  <= wf_meta_ff;
        end
    end

    // Access qualifiers; every write is locked out while a command runs
    assign wr_ok     = i_uc_wr && !exec_busy;
    assign cmd_start = wr_ok && (i_uc_addr == `DCH_OFF_STATUS);
    assign st_rd     = i_uc_rd &&
                       (exec_busy || i_uc_addr == `DCH_OFF_STATUS);

    dch_cmd_exec u_exec (
        .i_clk         (i_clk),
        .i_reset       (i_reset),
        .i_start       (cmd_start),
        .i_drive_ready (rdy_sync_ff),
        .i_write_fault (wf_sync_ff),
        .o_busy        (exec_busy),
        .o_done        (exec_done),
        .o_error       (exec_err)
    );

    // Busy and progress flags follow the executor, registered out
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_busy                <= 1'b0;
            o_command_in_progress <= 1'b0;
        end else begin
            o_busy                <= exec_busy || cmd_start;
            o_command_in_progress <= exec_busy || cmd_start;
        end
    end

    // Command and drive/head registers
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cmd_ff <= `DCH_RST_BYTE;
            sdh_ff <= `DCH_RST_BYTE;
        end else if (wr_ok) begin
            if (i_uc_addr == `DCH_OFF_STATUS)
                cmd_ff <= i_uc_wdata;
            if (i_uc_addr == `DCH_OFF_SDH)
                sdh_ff <= {i_uc_wdata[7:5], 1'b0, i_uc_wdata[3:0]};
        end
    end

    // Head lines stay with the microcontroller; only the ID byte is built
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_id_format_byte <= `DCH_RST_BYTE;
        end else begin
            o_id_format_byte <= {i_bad_block, sdh_ff[6:5], 1'b0,
                head_field(sdh_ff, i_four_bit_head)};
        end
    end

    // Interrupt: completion sets; status read or command write clears.
    // Set wins so a completion in the clearing cycle is not lost.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_ff <= 1'b0;
        end else if (exec_done) begin
            irq_ff <= 1'b1;
        end else if (st_rd || cmd_start) begin
            irq_ff <= 1'b0;
        end
    end

    // Ready/fault snapshot at completion, released by first status read
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            lat_ff     <= 1'b0;
            lat_rdy_ff <= 1'b0;
            lat_wf_ff  <= 1'b0;
        end else if (exec_done) begin
            lat_ff     <= 1'b1;
            lat_rdy_ff <= rdy_sync_ff;
            lat_wf_ff  <= wf_sync_ff;
        end else if (st_rd) begin
            lat_ff <= 1'b0;
        end
    end

    assign rdy_view = lat_ff ? lat_rdy_ff : rdy_sync_ff;
    assign wf_view  = lat_ff ? lat_wf_ff : wf_sync_ff;

    // Status image; busy-only bits only ever show while a command runs
    always_comb begin
        status_img                = 8'h00;
        status_img[`DCH_ST_BUSY]  = exec_busy;
        status_img[`DCH_ST_RDY]   = rdy_view;
        status_img[`DCH_ST_WF]    = wf_view;
        status_img[`DCH_ST_SEEK]  = `DCH_SEEK_TIED;
        status_img[`DCH_ST_BUFFER_DATA_REQUEST]  = exec_busy && i_buffer_data_request;
        status_img[`DCH_ST_CIP]   = exec_busy;
        status_img[`DCH_ST_ERR]   = exec_err;
    end

    // Legacy host busy: set at reset and on selection; set beats clear
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            leg_busy_ff <= 1'b1;
        end else if (i_legacy_select) begin
            leg_busy_ff <= 1'b1;
        end else if (i_legacy_busy_clr) begin
            leg_busy_ff <= 1'b0;
        end
    end

    // Only command/data and direction bits are writable
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            leg_wr_ff <= 2'b00;
        end else if (wr_ok && i_uc_addr == `DCH_OFF_LEGACY) begin
            leg_wr_ff <= i_uc_wdata[2:1];
        end
    end

    // Legacy port image, bits 7 and 6 hard ones
    assign nxt_legacy = {2'b11, i_host_interrupt_out,
                         i_host_dma_request_out, leg_busy_ff,
                         leg_wr_ff, i_host_xfer_en};

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_legacy_status <= 8'hc8;
        end else begin
            o_legacy_status <= nxt_legacy;
        end
    end

    // Drive configuration and host pointer registers
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_ff    <= `DCH_RST_BYTE;
            ptr_lo_ff <= `DCH_RST_BYTE;
            ptr_hi_ff <= 7'h00;
        end else if (wr_ok) begin
            if (i_uc_addr == `DCH_OFF_DRVCFG)
                cfg_ff <= i_uc_wdata;
            if (i_uc_addr == `DCH_OFF_PTR_LO)
                ptr_lo_ff <= i_uc_wdata;
            if (i_uc_addr == `DCH_OFF_PTR_HI)
                ptr_hi_ff <= i_uc_wdata[6:0];
        end
    end

    // Armed reload waits for a zero count, immediate if already zero
    assign arm_load = arm_ff && (xfer_ff == 12'h000);

    // Arm latch; a new arm in the load cycle keeps it set
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            arm_ff <= 1'b0;
        end else if (i_arm_host_pointer) begin
            arm_ff <= 1'b1;
        end else if (arm_load) begin
            arm_ff <= 1'b0;
        end
    end

    // Transfer and host buffer counters reload together
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            xfer_ff <= `DCH_RST_XFER;
            hbc_ff  <= `DCH_RST_PTR;
        end else if (arm_load) begin
            xfer_ff <= i_host_xfer_count;
            hbc_ff  <= {ptr_hi_ff, ptr_lo_ff};
        end else if (i_host_byte_done && xfer_ff != 12'h000) begin
            xfer_ff <= xfer_ff - 12'h001;
            hbc_ff  <= hbc_ff + 15'h0001;
        end
    end

    // Read mux; a running command forces the status image everywhere
    always_comb begin
        nxt_rdata = 8'h00;
        if (exec_busy) begin
            nxt_rdata = status_img;
        end else begin
            unique case (i_uc_addr)
                `DCH_OFF_SDH: nxt_rdata = {sdh_ff[7:4],
                    head_field(sdh_ff, i_four_bit_head)};
                `DCH_OFF_STATUS: nxt_rdata = status_img;
                `DCH_OFF_LEGACY: nxt_rdata = nxt_legacy;
                `DCH_OFF_PTR_LO: nxt_rdata = ptr_lo_ff;
                `DCH_OFF_PTR_HI: nxt_rdata = {1'b0, ptr_hi_ff};
                default:         nxt_rdata = 8'h00;
            endcase
        end
    end

    // Read data held until the next read
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_uc_rdata <= `DCH_RST_BYTE;
        end else if (i_uc_rd) begin
            o_uc_rdata <= nxt_rdata;
        end
    end

    // Remaining register outputs
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_command             <= `DCH_RST_BYTE;
            o_disk_ctrl_interrupt <= 1'b0;
            o_drive_config        <= `DCH_RST_BYTE;
            o_arm_host_pointer    <= 1'b0;
            o_host_buf_cnt        <= `DCH_RST_PTR;
            o_xfer_cnt            <= `DCH_RST_XFER;
        end else begin
            o_command             <= cmd_ff;
            o_disk_ctrl_interrupt <= irq_ff;
            o_drive_config        <= cfg_ff;
            o_arm_host_pointer    <= arm_ff;
            o_host_buf_cnt        <= hbc_ff;
            o_xfer_cnt            <= xfer_ff;
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_cmd_write;
        i_uc_wr && i_uc_addr == `DCH_OFF_STATUS && !exec_busy;
    endsequence

    sequence s_idle_status_read;
        i_uc_rd && i_uc_addr == `DCH_OFF_STATUS && !exec_busy;
    endsequence

    // Busy checked only on the first cycle: a drive abort may end it next
    a_cmd_starts_busy: assert property (
        s_cmd_write |=> o_busy && o_command_in_progress && exec_busy)
        else $error("command write did not raise busy");

    a_cmd_clears_irq: assert property (
        s_cmd_write and !exec_done |=> !irq_ff)
        else $error("command write left interrupt set");

    a_read_clears_irq: assert property (
        s_idle_status_read and !exec_done |=>
            !irq_ff ##1 !o_disk_ctrl_interrupt)
        else $error("status read left interrupt set");

    a_idle_status_bits: assert property (
        s_idle_status_read |=> o_uc_rdata[7] == 1'b0 &&
            o_uc_rdata[3:1] == 3'b000 && o_uc_rdata[4] == 1'b1)
        else $error("fixed status bits wrong");

    a_busy_write_lock: assert property (
        exec_busy && i_uc_wr |=> $stable(sdh_ff) && $stable(ptr_lo_ff))
        else $error("write accepted during command");

    a_busy_read_stat: assert property (
        exec_busy && i_uc_rd |=> o_uc_rdata[4] && o_uc_rdata[1])
        else $error("busy read did not return status");

    a_abort_on_drive: assert property (
        exec_busy && (!rdy_sync_ff || wf_sync_ff) |=> !exec_busy && exec_err)
        else $error("command not aborted on drive fault");

    a_done_latches: assert property (
        exec_done |=> lat_ff && lat_rdy_ff == $past(rdy_sync_ff) &&
            lat_wf_ff == $past(wf_sync_ff))
        else $error("status not latched at completion");

    a_legacy_ones: assert property (
        ##1 o_legacy_status[7:6] == 2'b11)
        else $error("legacy bits 7..6 not one");

    a_arm_reload: assert property (
        arm_load && !i_arm_host_pointer |=> !arm_ff &&
            hbc_ff == {$past(ptr_hi_ff), $past(ptr_lo_ff)} &&
            xfer_ff == $past(i_host_xfer_count))
        else $error("armed reload failed");

    a_head_three: assert property (
        !i_four_bit_head |=> ##1 (o_id_format_byte[4:3] == 2'b00 ||
            $past(i_four_bit_head)))
        else $error("head field wider than three bits");
endmodule

// ---- tb/dch_uc_model.sv ----
// Microcontroller model: register bus master and head line driver
`timescale 1ns/100ps
module dch_uc_model (
    input  wire logic i_clk,
    input  wire logic i_four_bit_head,
    output logic [7:0] o_uc_addr,
    output logic [7:0] o_uc_wdata,
    output logic       o_uc_wr,
    output logic       o_uc_rd,
    output logic [3:0] o_head_lines
);
    // Bus idle with strobes low from time zero
    initial begin
        o_uc_addr = 8'h00;
        o_uc_wdata = 8'h00;
        o_uc_wr = 1'b0;
        o_uc_rd = 1'b0;
        o_head_lines = 4'h0;
    end

    // One strobe edge per access; an idle cycle always separates accesses
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge i_clk);
        #2;
        o_uc_addr = a;
        o_uc_wdata = d;
        if (w) begin
            o_uc_wr = 1'b1;
        end else begin
            o_uc_rd = 1'b1;
        end
        @(posedge i_clk);
        #2;
        o_uc_wr = 1'b0;
        o_uc_rd = 1'b0;
        o_uc_wdata = ~d; // Stale data must not look valid
        if (w && a == 8'h26) begin
            o_head_lines = i_four_bit_head ? d[3:0]
                                           : {1'b0, d[2:0]};
        end
    endtask

    // Announce the next host phase in the legacy port
    task automatic legacy_phase(input logic cmd_phase, input logic host_rd);
        access(1'b1, 8'h2d,
               {5'h1f, cmd_phase, host_rd, 1'b1});
    endtask
endmodule

// ---- tb/dch_regs_bench.sv ----
// Self-checking bench of the disk controller register block
`timescale 1ns/100ps
module dch_regs_bench;
    logic i_clk, i_reset, rdy, flt, four, bad, buffer_data_request, hirq, hdma, hxen;
    logic lsel, lclr, arm, bdone, wr, rd_s, busy, command_in_progress, disk_ctrl_interrupt, armo;
    logic [7:0] addr, wdata, rdata, cmd, idb, lst, cfg, v, e;
    logic [11:0] xcnt, xfr;
    logic [14:0] hbc, p;
    logic [3:0] head;
    logic [7:0] exp_q[$];
    int err_total, check_count, seed;

    dch_regs DUT (.i_clk(i_clk), .i_reset(i_reset), .i_uc_addr(addr),
        .i_uc_wdata(wdata), .i_uc_wr(wr), .i_uc_rd(rd_s),
        .i_drive_ready_in(rdy), .i_write_fault_in(flt),
        .i_four_bit_head(four), .i_bad_block(bad),
        .i_buffer_data_request(buffer_data_request), .i_host_interrupt_out(hirq),
        .i_host_dma_request_out(hdma), .i_host_xfer_en(hxen),
        .i_legacy_select(lsel), .i_legacy_busy_clr(lclr),
        .i_arm_host_pointer(arm), .i_host_byte_done(bdone),
        .i_host_xfer_count(xcnt), .o_uc_rdata(rdata), .o_command(cmd),
        .o_busy(busy), .o_command_in_progress(command_in_progress),
        .o_disk_ctrl_interrupt(disk_ctrl_interrupt), .o_id_format_byte(idb),
        .o_legacy_status(lst), .o_drive_config(cfg),
        .o_arm_host_pointer(armo), .o_host_buf_cnt(hbc), .o_xfer_cnt(xfr));

    dch_uc_model uc (.i_clk(i_clk), .i_four_bit_head(four),
        .o_uc_addr(addr), .o_uc_wdata(wdata), .o_uc_wr(wr),
        .o_uc_rd(rd_s), .o_head_lines(head));

    // 50 MHz clock
    always #10 i_clk = ~i_clk;

    task automatic results;
        $display("Counts: %0d checks, %0d errors", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("Error at %0t: byte %h, expected %h", $time, g, x);
        end
    endtask

    task automatic chk_cnt(input logic [14:0] g, input logic [14:0] x);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("Error at %0t: count %h, expected %h", $time, g, x);
        end
    endtask

    task automatic chk_bit(input logic g, input logic x);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("Error at %0t: flag %b, expected %b", $time, g, x);
        end
    endtask

    // Settle past the edge so flags are read after they land
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask

    task automatic wait_idle;
        for (int n = 0; n < 300; n++) begin
            wait_cyc(1);
            if (busy === 1'b0) return;
        end
        err_total++;
        $display("Error at %0t: command never finished", $time);
        results;
    endtask

    // Expected read byte queued before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        uc.access(1'b0, a, 8'h00);
    endtask

    task automatic pulse(input int s);
        @(posedge i_clk);
        #2;
        case (s)
            0: lclr = 1'b1;
            1: lsel = 1'b1;
            2: arm = 1'b1;
            default: bdone = 1'b1;
        endcase
        @(posedge i_clk);
        #2;
        {lclr, lsel, arm, bdone} = 4'h0;
    endtask

    // Read data is registered at the strobe edge, so look just after it
    always @(posedge i_clk) begin
        #1;
        if (rd_s === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("Error at %0t: read with no expectation", $time);
            end else begin
                chk_byte(rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        {i_clk, flt, four, bad, hirq, hdma, hxen} = 7'h00;
        {lsel, lclr, arm, bdone} = 4'h0;
        {i_reset, rdy, buffer_data_request} = 3'h7;
        xcnt = 12'h000;
        seed = $urandom(32'ha833);
        wait_cyc(8);
        chk_byte(lst, 8'hc8);
        i_reset = 1'b0;
        wait_cyc(4);
        rd(8'h27, 8'h50);
        $display("Test idle status done");
        for (int m = 0; m < 2; m++) begin
            v = 8'($urandom);
            four = m[0];
            bad = v[4];
            uc.access(1'b1, 8'h26, v);
            e = m[0] ? (v & 8'hef) : (v & 8'he7);
            rd(8'h26, e);
            chk_byte({4'h0, head}, {4'h0, e[3:0]});
            chk_byte(idb, {v[4], v[6:5], 1'b0, e[3:0]});
        end
        $display("Test head field done");
        uc.access(1'b1, 8'h30, 8'h5a);
        uc.access(1'b1, 8'h27, 8'h20);
        chk_bit(busy, 1'b1);
        chk_bit(command_in_progress, 1'b1);
        rd(8'h30, 8'hda);
        chk_byte(cmd, 8'h20);
        uc.access(1'b1, 8'h30, 8'ha5);
        wait_idle();
        wait_cyc(2);
        chk_bit(disk_ctrl_interrupt, 1'b1);
        rd(8'h30, 8'h5a);
        $display("Test command done");
        for (int k = 0; k < 2; k++) begin
            rdy = k[0];
            flt = k[0];
            wait_cyc(4);
            uc.access(1'b1, 8'h27, 8'h30);
            // Interrupt output trails its flag by one cycle
            wait_cyc(1);
            chk_bit(disk_ctrl_interrupt, 1'b0);
            wait_idle();
            {rdy, flt} = 2'b10;
            wait_cyc(4);
            chk_bit(disk_ctrl_interrupt, 1'b1);
            e = k[0] ? 8'h71 : 8'h11;
            rd(8'h27, e);
            wait_cyc(1);
            chk_bit(disk_ctrl_interrupt, 1'b0);
            rd(8'h27, 8'h51);
        end
        $display("Test abort done");
        pulse(0);
        for (int j = 0; j < 4; j++) begin
            {hirq, hdma, hxen} = 3'($urandom);
            uc.legacy_phase(j[1], j[0]);
            e = {2'b11, hirq, hdma, 1'b0, j[1], j[0], hxen};
            rd(8'h2d, e);
            chk_byte(lst, e);
        end
        pulse(1);
        rd(8'h2d, {2'b11, hirq, hdma, 1'b1, 2'b11, hxen});
        $display("Test legacy port done");
        // Configuration byte is write-only; it reads back as zero
        v = 8'($urandom);
        uc.access(1'b1, 8'h2e, v);
        rd(8'h2e, 8'h00);
        chk_byte(cfg, v);
        p = 15'($urandom);
        uc.access(1'b1, 8'h30, p[7:0]);
        uc.access(1'b1, 8'h31, {1'b1, p[14:8]});
        rd(8'h30, p[7:0]);
        rd(8'h31, {1'b0, p[14:8]});
        xcnt = 12'h003;
        pulse(2);
        wait_cyc(3);
        chk_cnt(hbc, p);
        chk_cnt(15'(xfr), 15'h0003);
        chk_bit(armo, 1'b0);
        xcnt = 12'h002;
        pulse(2);
        pulse(3);
        pulse(3);
        wait_cyc(1);
        chk_bit(armo, 1'b1);
        chk_cnt(hbc, p + 15'h0002);
        pulse(3);
        wait_cyc(3);
        chk_cnt(hbc, p);
        chk_cnt(15'(xfr), 15'h0002);
        chk_bit(armo, 1'b0);
        $display("Test host pointer done");
        results();
    end
endmodule
